/* File: design/psc_power_state_control.sv */
// Power state controller with register and pin-driven state selection
// Contract
// R1: Linear regulators auto-bypass on low input unless auto_bypass_disable is set.
// R2: Each linear regulator bypasses while its force_bypass bit is set.
// R3: One coarse_reg_enable bit per output enables its coarse regulator.
// R4: Coarse shunt ties every enabled coarse regulator output to input supply.
// R5: Low-voltage output-B variant disables output-B coarse regulator and shunt.
// R6: Host writes power_state_select; device enters requested state.
// R7: Register-controlled mode keeps bus pull-ups enabled in low states.
// R8: Pin mode disables pull-ups; bus pins are host-driven inputs.
// R9: Pins decode 11 active, 01 reduced, 00 hibernate, 10 bus start.
// R10: Pin mode permits only neighbour transitions; active-hibernate moves forbidden.
// R11: Bus start clears pin mode; optionally forces active state. Code acts on a start only in active state.
// R12: Reset leaves device active with full current available.
// R13: Reduced-bias state selects low-state peak currents and output-B voltage.
// R14: Reduced-bias routes converter B counts to separate result pair.
// R15: Hibernate turns off converters and regulators, turns on enabled coarse regulators.
// R16: Hibernate halts measurements and charge counting.
// R17: Hibernate keeps register access but never asserts interrupt.
// R18: Host uses pin mode only with hardware holding lines during reset.
// R19: Pin mode only when this device is sole bus target.
// R20: Pin levels pass two flip-flops and must stay stable before use.
// R21: Forbidden pin combinations are ignored; current state is held.
`timescale 1ns/10ps
`include "psc_regs.svh"
module psc_power_state_control #(
  parameter int STABLE_CYCLES = `PSC_STABLE_CYCLES_DEF,
  parameter bit LOW_VOLT_B = 1'b0
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  // Control bits
  input wire psc_pkg::psc_ctrl_s CTRL_I,
  input wire logic CTRL_WRITE_I,
  // Analog status
  input wire logic INPUT_SUPPLY_LOW_I,
  input wire logic IRQ_REQ_I,
  // Bus pins
  input wire logic SCL_I,
  input wire logic SDA_I,
  // Status and actuation
  output psc_pkg::psc_state_e STATE_O,
  output psc_pkg::psc_out_s ACT_O,
  output logic PULLUP_EN_O,
  output logic PIN_MODE_O,
  output logic LOW_STATE_SEL_O,
  output logic COUNT_B_LOW_SEL_O,
  output logic MEAS_EN_O,
  output logic COUNT_EN_O,
  output logic IRQ_O
);
  localparam int CW = $clog2(STABLE_CYCLES + 1);

  // Elaboration check: a zero count would let every glitch through
  if (STABLE_CYCLES < 1)
  begin
    $error("STABLE_CYCLES must be at least 1");
  end

  logic scl_s1;
  logic scl_s2;
  logic sda_s1;
  logic sda_s2;
  psc_pkg::psc_pin_e pin_code;
  psc_pkg::psc_pin_e pin_prev;
  psc_pkg::psc_pin_e pin_stable;
  logic stable_new;
  logic [CW-1:0] stab_cnt;
  logic pin_mode;
  logic pin_mode_d;
  psc_pkg::psc_state_e state;
  psc_pkg::psc_state_e next_state;
  psc_pkg::psc_state_e reg_req;
  logic start_forces_active;

  // Two-stage synchronisers on the bus pins
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end
    else
    begin
      scl_s1 <= SCL_I; // R20
      scl_s2 <= scl_s1;
      sda_s1 <= SDA_I;
      sda_s2 <= sda_s1;
    end
  end

  // Pin level decode
  always_comb
  begin
    case ({scl_s2, sda_s2})
      2'h3: pin_code = psc_pkg::PSC_PIN_ACTIVE; // R9
      2'h1: pin_code = psc_pkg::PSC_PIN_REDUCED;
      2'h0: pin_code = psc_pkg::PSC_PIN_HIBERNATE;
      default: pin_code = psc_pkg::PSC_PIN_START;
    endcase
  end

  // Filter glitches while the host swings both lines
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      pin_prev <= psc_pkg::PSC_PIN_ACTIVE;
      pin_stable <= psc_pkg::PSC_PIN_ACTIVE;
      stab_cnt <= '0;
      stable_new <= 1'b0;
    end
    else
    begin
      pin_prev <= pin_code;
      stable_new <= 1'b0;
      if (pin_code != pin_prev)
      begin
        stab_cnt <= '0;
      end
      else if (stab_cnt < CW'(STABLE_CYCLES - 1))
      begin
        stab_cnt <= stab_cnt + CW'(1);
      end
      else if (pin_stable != pin_code)
      begin
        pin_stable <= pin_code; // R20
        stable_new <= 1'b1;
      end
    end
  end

  // Pin mode and start handling
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      pin_mode <= 1'b0;
      start_forces_active <= 1'b0;
    end
    else if (CTRL_WRITE_I)
    begin
      pin_mode <= CTRL_I.pin_state_control_enable;
      start_forces_active <= CTRL_I.start_forces_active;
    end
    else if (pin_mode && stable_new && pin_stable == psc_pkg::PSC_PIN_START && state == psc_pkg::PSC_ACTIVE)
    begin
      pin_mode <= 1'b0; // R11
    end
  end

  always_comb
  begin
    case (CTRL_I.power_state_select)
      `PSC_STATE_REDUCED: reg_req = psc_pkg::PSC_REDUCED;
      `PSC_STATE_HIBERNATE: reg_req = psc_pkg::PSC_HIBERNATE;
      default: reg_req = psc_pkg::PSC_ACTIVE;
    endcase
  end

  // State transitions
  always_comb
  begin
    next_state = state;
    pin_mode_d = pin_mode && stable_new;
    if (CTRL_WRITE_I)
    begin
      next_state = reg_req; // R6
    end
    else if (pin_mode_d)
    begin
      case (state)
        psc_pkg::PSC_ACTIVE:
        begin
          if (pin_stable == psc_pkg::PSC_PIN_REDUCED)
          begin
            next_state = psc_pkg::PSC_REDUCED; // R10
          end
          else if (pin_stable == psc_pkg::PSC_PIN_START && start_forces_active)
          begin
            next_state = psc_pkg::PSC_ACTIVE; // R11
          end
          else
          begin
            next_state = state; // R21
          end
        end
        psc_pkg::PSC_REDUCED:
        begin
          if (pin_stable == psc_pkg::PSC_PIN_ACTIVE)
          begin
            next_state = psc_pkg::PSC_ACTIVE; // R10
          end
          else if (pin_stable == psc_pkg::PSC_PIN_HIBERNATE)
          begin
            next_state = psc_pkg::PSC_HIBERNATE;
          end
          else
          begin
            next_state = state; // R21
          end
        end
        psc_pkg::PSC_HIBERNATE:
        begin
          if (pin_stable == psc_pkg::PSC_PIN_REDUCED)
          begin
            next_state = psc_pkg::PSC_REDUCED; // R10
          end
          else
          begin
            next_state = state; // R21
          end
        end
        default: next_state = state; // R21
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state <= psc_pkg::PSC_ACTIVE; // R12
    end
    else
    begin
      state <= next_state;
    end
  end

  // Regulator actuation; registered so outputs are glitch free
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ACT_O.bypass_b <= 1'b0;
      ACT_O.bypass_c <= 1'b0;
      ACT_O.coarse_on <= 3'h0;
      ACT_O.coarse_shunt <= 3'h0;
      ACT_O.conv_on <= 1'b1;
    end
    else
    begin
      ACT_O.bypass_b <= (state != psc_pkg::PSC_HIBERNATE) &&
        (CTRL_I.force_bypass_b || (INPUT_SUPPLY_LOW_I && !CTRL_I.auto_bypass_disable)); // R1 R2
      ACT_O.bypass_c <= (state != psc_pkg::PSC_HIBERNATE) &&
        (CTRL_I.force_bypass_c || (INPUT_SUPPLY_LOW_I && !CTRL_I.auto_bypass_disable)); // R1 R2
      for (int i = 0; i < 3; i++)
      begin
        // Variant without coarse B keeps output B unaffected
        ACT_O.coarse_on[i] <= (state == psc_pkg::PSC_HIBERNATE) && CTRL_I.coarse_reg_enable[i] &&
          !(LOW_VOLT_B && i == 1); // R3 R5 R15
        ACT_O.coarse_shunt[i] <= (state == psc_pkg::PSC_HIBERNATE) && CTRL_I.coarse_reg_enable[i] &&
          CTRL_I.coarse_reg_shunt && !(LOW_VOLT_B && i == 1); // R4 R5
      end
      ACT_O.conv_on <= state != psc_pkg::PSC_HIBERNATE; // R15
    end
  end

  // State and selector outputs
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      STATE_O <= psc_pkg::PSC_ACTIVE;
      LOW_STATE_SEL_O <= 1'b0;
      COUNT_B_LOW_SEL_O <= 1'b0;
      MEAS_EN_O <= 1'b1;
      COUNT_EN_O <= 1'b1;
    end
    else
    begin
      STATE_O <= state;
      LOW_STATE_SEL_O <= state == psc_pkg::PSC_REDUCED; // R13
      COUNT_B_LOW_SEL_O <= state == psc_pkg::PSC_REDUCED; // R14
      MEAS_EN_O <= state != psc_pkg::PSC_HIBERNATE; // R16
      COUNT_EN_O <= state != psc_pkg::PSC_HIBERNATE; // R16
    end
  end

  // Bus pin control; pull-ups return one clock after pin mode ends
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      PULLUP_EN_O <= 1'b1;
      PIN_MODE_O <= 1'b0;
    end
    else
    begin
      PULLUP_EN_O <= !pin_mode; // R7 R8
      PIN_MODE_O <= pin_mode;
    end
  end

  // Interrupt gate; requests raised in hibernate are dropped, not held
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      IRQ_O <= 1'b0;
    end
    else
    begin
      IRQ_O <= IRQ_REQ_I && state != psc_pkg::PSC_HIBERNATE; // R17
    end
  end
endmodule

/* File: design/psc_regs.svh */
// Constants for the power state control block
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH
`define PSC_STATE_ACTIVE 2'h0
`define PSC_STATE_REDUCED 2'h1
`define PSC_STATE_HIBERNATE 2'h2
`define PSC_STABLE_CYCLES_DEF 8
`define PSC_RST_STATE 2'h0
`endif

/* File: design/psc_pkg.sv */
// Types for the power state control block
package psc_pkg;
  typedef enum logic [1:0] {PSC_ACTIVE, PSC_REDUCED, PSC_HIBERNATE} psc_state_e;
  typedef enum logic [1:0] {PSC_PIN_ACTIVE, PSC_PIN_REDUCED, PSC_PIN_HIBERNATE, PSC_PIN_START} psc_pin_e;
  typedef struct packed {
    logic auto_bypass_disable;
    logic force_bypass_b;
    logic force_bypass_c;
    logic [2:0] coarse_reg_enable;
    logic coarse_reg_shunt;
    logic [1:0] power_state_select;
    logic pin_state_control_enable;
    logic start_forces_active;
  } psc_ctrl_s;
  typedef struct packed {
    logic bypass_b;
    logic bypass_c;
    logic [2:0] coarse_on;
    logic [2:0] coarse_shunt;
    logic conv_on;
  } psc_out_s;
endpackage

/* File: sim/psc_power_state_control_assertions.sv */
// Port checker for the power state control block
`timescale 1ns/10ps
module psc_checker #(
  parameter bit LOW_VOLT_B = 1'b0
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  // Control inputs
  input wire psc_pkg::psc_ctrl_s CTRL_I,
  input wire logic CTRL_WRITE_I,
  input wire logic INPUT_SUPPLY_LOW_I,
  // Outputs watched
  input wire psc_pkg::psc_state_e STATE_O,
  input wire psc_pkg::psc_out_s ACT_O,
  input wire logic PULLUP_EN_O,
  input wire logic PIN_MODE_O,
  input wire logic LOW_STATE_SEL_O,
  input wire logic COUNT_B_LOW_SEL_O,
  input wire logic MEAS_EN_O,
  input wire logic COUNT_EN_O,
  input wire logic IRQ_O
);
  localparam psc_pkg::psc_state_e act = psc_pkg::PSC_ACTIVE;
  localparam psc_pkg::psc_state_e red = psc_pkg::PSC_REDUCED;
  localparam psc_pkg::psc_state_e hib = psc_pkg::PSC_HIBERNATE;
  localparam logic [2:0] keep_mask = {1'b1, !LOW_VOLT_B, 1'b1};
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  // State outputs lag by one edge, so each check waits for a settled state
  write_sel_a: assert property (CTRL_WRITE_I && CTRL_I.power_state_select != 2'h3 |->
    ##2 STATE_O == $past(CTRL_I.power_state_select, 2)) else $error("state after write wrong");
  hib_off_a: assert property (STATE_O == hib && $stable(STATE_O) |->
    !(MEAS_EN_O || COUNT_EN_O || ACT_O.conv_on || IRQ_O)) else $error("hibernate left something on");
  red_sel_a: assert property (STATE_O == red && $stable(STATE_O) |->
    LOW_STATE_SEL_O && COUNT_B_LOW_SEL_O) else $error("reduced selects missing");
  act_full_a: assert property (STATE_O == act && $stable(STATE_O) |->
    MEAS_EN_O && COUNT_EN_O && ACT_O.conv_on && !LOW_STATE_SEL_O && ACT_O.coarse_on == 3'h0)
    else $error("active state outputs wrong");
  pullup_pin_a: assert property ($stable(PIN_MODE_O) |-> PULLUP_EN_O != PIN_MODE_O)
    else $error("pull-up not opposite pin mode");
  pullup_write_a: assert property (CTRL_WRITE_I |->
    ##2 PULLUP_EN_O == !$past(CTRL_I.pin_state_control_enable, 2)) else $error("pull-up not set by write");
  no_jump_a: assert property (PIN_MODE_O && !CTRL_WRITE_I && !$past(CTRL_WRITE_I) && STATE_O != red |=>
    STATE_O == $past(STATE_O) || STATE_O == red) else $error("forbidden pin move taken");
  bypass_a: assert property (!$past(RST_I) && STATE_O == act && $stable(STATE_O) |->
    {ACT_O.bypass_b, ACT_O.bypass_c} ==
    $past({2{INPUT_SUPPLY_LOW_I && !CTRL_I.auto_bypass_disable}} | {CTRL_I.force_bypass_b, CTRL_I.force_bypass_c}))
    else $error("bypass outputs wrong");
  coarse_a: assert property (STATE_O == hib && $stable(STATE_O) |->
    ACT_O.coarse_on == ($past(CTRL_I.coarse_reg_enable) & keep_mask) &&
    ACT_O.coarse_shunt == ($past(CTRL_I.coarse_reg_enable & {3{CTRL_I.coarse_reg_shunt}}) & keep_mask))
    else $error("coarse wrong");
endmodule
bind psc_power_state_control psc_checker #(.LOW_VOLT_B(LOW_VOLT_B)) i_chk (.*);

/* File: sim/psc_host_model.sv */
// Host model driving the bus pins as state levels
`timescale 1ns/10ps
module psc_host_model (
  // Pin levels toward the device
  output logic scl_o,
  output logic sda_o
);
  // Idle high, as the pull-ups leave the lines
  initial
  begin
    {scl_o, sda_o} = 2'h3;
  end
  // Sole target on the bus; lines held through host reset
  task drive(input logic [1:0] code);
    {scl_o, sda_o} = code;
  endtask
endmodule

/* File: sim/psc_power_state_control_tb.sv */
// Testbench for the power state control block
`timescale 1ns/10ps
module psc_power_state_control_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_en = 1'b0;
  logic low = 1'b0;
  logic irq_req = 1'b1;
  logic scl, sda, pull, pin, lsel, csel, meas, cnt, irq;
  psc_pkg::psc_ctrl_s ctrl = '0;
  psc_pkg::psc_state_e st;
  psc_pkg::psc_out_s act;
  psc_pkg::psc_out_s act_lv;
  int n_errors = 0;
  int total_checks = 0;
  logic [1:0] codes [8] = '{2'h1, 2'h0, 2'h3, 2'h1, 2'h3, 2'h0, 2'h3, 2'h2};
  logic [1:0] want [8] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0};
  logic [4:0] force_bypass [4] = '{5'h03, 5'h10, 5'h1A, 5'h15};
  initial
  begin
    forever #50 clk = ~clk;
  end
  psc_host_model i_host (.scl_o(scl), .sda_o(sda));
  // Short stability count keeps pin tests quick
  psc_power_state_control #(.STABLE_CYCLES(2)) i_dut (
    .CORE_CLK_I(clk),
    .RST_I(rst),
    .CTRL_I(ctrl),
    .CTRL_WRITE_I(wr_en),
    .INPUT_SUPPLY_LOW_I(low),
    .IRQ_REQ_I(irq_req),
    .SCL_I(scl),
    .SDA_I(sda),
    .STATE_O(st),
    .ACT_O(act),
    .PULLUP_EN_O(pull),
    .PIN_MODE_O(pin),
    .LOW_STATE_SEL_O(lsel),
    .COUNT_B_LOW_SEL_O(csel),
    .MEAS_EN_O(meas),
    .COUNT_EN_O(cnt),
    .IRQ_O(irq)
  );
  // Low-voltage output-B variant, only its coarse outputs are compared
  psc_power_state_control #(.STABLE_CYCLES(2), .LOW_VOLT_B(1'b1)) i_dut_lv (
    .CORE_CLK_I(clk),
    .RST_I(rst),
    .CTRL_I(ctrl),
    .CTRL_WRITE_I(wr_en),
    .INPUT_SUPPLY_LOW_I(low),
    .IRQ_REQ_I(irq_req),
    .SCL_I(scl),
    .SDA_I(sda),
    .STATE_O(),
    .ACT_O(act_lv),
    .PULLUP_EN_O(),
    .PIN_MODE_O(),
    .LOW_STATE_SEL_O(),
    .COUNT_B_LOW_SEL_O(),
    .MEAS_EN_O(),
    .COUNT_EN_O(),
    .IRQ_O()
  );
  task chk(input logic [9:0] got, input logic [9:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task chk_state(input logic [1:0] s, input logic pl);
    chk({st, lsel, csel, meas, cnt, act.conv_on, irq, pull, pin}, {s, s == 2'h1, s == 2'h1, {4{s != 2'h2}}, pl, !pl});
  endtask
  task wr(input logic [1:0] s, input logic p);
    ctrl.power_state_select = s;
    ctrl.pin_state_control_enable = p;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    ctrl.start_forces_active = 1'b1;
    ctrl.coarse_reg_enable = 3'h6;
    ctrl.coarse_reg_shunt = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk_state(2'h0, 1'b1);
    $display("reset test done");
    for (int i = 2; i >= 0; i--)
    begin
      wr(i[1:0], 1'b0);
      chk_state(i[1:0], 1'b1);
      chk({4'h0, act.coarse_on, act.coarse_shunt}, (i == 2) ? 10'h036 : 10'h000);
      chk({4'h0, act_lv.coarse_on, act_lv.coarse_shunt}, (i == 2) ? 10'h024 : 10'h000);
    end
    low = 1'b1;
    foreach (force_bypass[i])
    begin
      {ctrl.auto_bypass_disable, ctrl.force_bypass_b, ctrl.force_bypass_c} = force_bypass[i][4:2];
      repeat (2) @(negedge clk);
      chk({8'h00, act.bypass_b, act.bypass_c}, {8'h00, force_bypass[i][1:0]});
    end
    irq_req = 1'b0;
    repeat (2) @(negedge clk);
    chk({9'h000, irq}, 10'h000);
    irq_req = 1'b1;
    $display("register test done");
    wr(2'h0, 1'b1);
    chk_state(2'h0, 1'b0);
    // Forbidden codes sit between legal ones; last code is a bus start
    foreach (codes[i])
    begin
      i_host.drive(codes[i]);
      repeat (9) @(negedge clk);
      chk_state(want[i], i == 7);
    end
    i_host.drive(2'h3);
    $display("pin test done");
    // Mid-run reset out of hibernate with pin mode on
    wr(2'h2, 1'b1);
    chk_state(2'h2, 1'b0);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk_state(2'h0, 1'b1);
    $display("restart test done");
    complete_run();
  end
endmodule
